// ==== tapp_top.v ====
// Summary of operation
// R1: Tester keeps test clock at most half the double rate input clock.
// R2: Data input sampled on rising test clock edge, used only while shifting.
// R3: Data output changes on falling test clock edge, LSB first.
// R4: Data output floats whenever no shift is in progress.
// R5: Mode select sampled on rising test clock edge picks next state.
// R6: Test reset clears data registers, loads instruction 0010 asynchronously.
// R7: Test reset returns controller to initial state, independent of test clock.
// R8: Standard sixteen state controller; shifting only in shift states.
`timescale 1ns/10ps
`default_nettype none
`include "tapp_regs.vh"
module tapp_top #(
    parameter IDW = 32
) (
    input  wire          sys_clk,
    input  wire          resetn,
    input  wire          tck,
    input  wire          tms,
    input  wire          tdi,
    input  wire          trst_n,
    input  wire [IDW-1:0] capture_in,
    output wire          tdo_out,
    output wire          tdo_oe_n,
    output wire [3:0]    instr_out,
    output wire [IDW-1:0] update_out
);
    // ------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------
    reg        rst_m_q;
    reg        rst_q;
    wire [3:0] pins_s;
    reg        tck_prev_q;
    reg        trst_ok_q;
    wire       tck_s;
    wire       tms_s;
    wire       tdi_s;
    wire       trst_s_n;
    wire       rise;
    wire       fall;
    wire       trst_a_n;

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_m_q <= 1'b0;
            rst_q   <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_q   <= rst_m_q;
        end
    end

    tapp_sync #(.W(4)) u_sync (
        .clk   (sys_clk),
        .rst_n (rst_q),
        .din   ({trst_n, tdi, tms, tck}),
        .dout  (pins_s)
    );
    assign tck_s    = pins_s[0];
    assign tms_s    = pins_s[1];
    assign tdi_s    = pins_s[2];
    assign trst_s_n = pins_s[3];

    // Test reset acts without test clock edges [R7]
    assign trst_a_n = rst_q & trst_n;

    // ------------------------------------------------------------
    // Test clock edge detection
    // ------------------------------------------------------------
    always @(posedge sys_clk or negedge trst_a_n) begin
        if (!trst_a_n) begin
            tck_prev_q <= 1'b0;
            trst_ok_q  <= 1'b0;
        end else begin
            tck_prev_q <= tck_s;
            trst_ok_q  <= trst_s_n;
        end
    end
    // No edge until the previous-value flop holds a synchronised sample
    assign rise = tck_s & ~tck_prev_q & trst_s_n & trst_ok_q;
    assign fall = ~tck_s & tck_prev_q & trst_s_n & trst_ok_q;

    // ------------------------------------------------------------
    // TAP state machine
    // ------------------------------------------------------------
    reg [15:0] st_q;
    reg [15:0] st_d;

    always @* begin
        st_d = st_q;
        case (st_q)
        `TAPP_ST_RESET:  st_d = tms_s ? `TAPP_ST_RESET  : `TAPP_ST_IDLE;
        `TAPP_ST_IDLE:   st_d = tms_s ? `TAPP_ST_SEL_DR : `TAPP_ST_IDLE;
        `TAPP_ST_SEL_DR: st_d = tms_s ? `TAPP_ST_SEL_IR : `TAPP_ST_CAP_DR;
        `TAPP_ST_CAP_DR: st_d = tms_s ? `TAPP_ST_EX1_DR : `TAPP_ST_SH_DR;
        `TAPP_ST_SH_DR:  st_d = tms_s ? `TAPP_ST_EX1_DR : `TAPP_ST_SH_DR;
        `TAPP_ST_EX1_DR: st_d = tms_s ? `TAPP_ST_UPD_DR : `TAPP_ST_PAU_DR;
        `TAPP_ST_PAU_DR: st_d = tms_s ? `TAPP_ST_EX2_DR : `TAPP_ST_PAU_DR;
        `TAPP_ST_EX2_DR: st_d = tms_s ? `TAPP_ST_UPD_DR : `TAPP_ST_SH_DR;
        `TAPP_ST_UPD_DR: st_d = tms_s ? `TAPP_ST_SEL_DR : `TAPP_ST_IDLE;
        `TAPP_ST_SEL_IR: st_d = tms_s ? `TAPP_ST_RESET  : `TAPP_ST_CAP_IR;
        `TAPP_ST_CAP_IR: st_d = tms_s ? `TAPP_ST_EX1_IR : `TAPP_ST_SH_IR;
        `TAPP_ST_SH_IR:  st_d = tms_s ? `TAPP_ST_EX1_IR : `TAPP_ST_SH_IR;
        `TAPP_ST_EX1_IR: st_d = tms_s ? `TAPP_ST_UPD_IR : `TAPP_ST_PAU_IR;
        `TAPP_ST_PAU_IR: st_d = tms_s ? `TAPP_ST_EX2_IR : `TAPP_ST_PAU_IR;
        `TAPP_ST_EX2_IR: st_d = tms_s ? `TAPP_ST_UPD_IR : `TAPP_ST_SH_IR;
        `TAPP_ST_UPD_IR: st_d = tms_s ? `TAPP_ST_SEL_DR : `TAPP_ST_IDLE;
        default:         st_d = `TAPP_ST_RESET;
        endcase
    end

    always @(posedge sys_clk or negedge trst_a_n) begin
        if (!trst_a_n) begin
            st_q <= `TAPP_ST_RESET; // [R7]
        end else if (rise) begin
            st_q <= st_d; // [R5] [R8]
        end
    end

    // ------------------------------------------------------------
    // State decode
    // ------------------------------------------------------------
    function tapp_in_state;
        input [15:0] st;
        input [15:0] code;
        begin
            tapp_in_state = |(st & code);
        end
    endfunction

    wire sh_dr   = tapp_in_state(st_q, `TAPP_ST_SH_DR);
    wire sh_ir   = tapp_in_state(st_q, `TAPP_ST_SH_IR);
    wire cap_dr  = tapp_in_state(st_q, `TAPP_ST_CAP_DR);
    wire upd_dr  = tapp_in_state(st_q, `TAPP_ST_UPD_DR);
    wire cap_ir  = tapp_in_state(st_q, `TAPP_ST_CAP_IR);
    wire upd_ir  = tapp_in_state(st_q, `TAPP_ST_UPD_IR);
    // Instruction reloads on entry to test-logic-reset
    wire nxt_rst = tapp_in_state(st_d, `TAPP_ST_RESET);

    // ------------------------------------------------------------
    // Instruction and data registers
    // ------------------------------------------------------------
    reg [3:0]     ir_q;
    reg [3:0]     irsh_q;
    reg [IDW-1:0] idsh_q;
    reg [IDW-1:0] cap_q;
    reg [IDW-1:0] upd_q;
    reg           byp_q;
    reg           tdo_q;
    reg           oe_n_q;
    wire          sel_id  = (ir_q == `TAPP_IR_IDREAD);
    wire          sel_cap = (ir_q == `TAPP_IR_CAPTURE);

    // All register moves happen on detected rising test clock edges
    always @(posedge sys_clk or negedge trst_a_n) begin
        if (!trst_a_n) begin
            ir_q   <= `TAPP_IR_IDREAD; // [R6]
            irsh_q <= 4'h0;
            idsh_q <= {IDW{1'b0}}; // [R6]
            cap_q  <= {IDW{1'b0}};
            upd_q  <= {IDW{1'b0}};
            byp_q  <= 1'b0;
        end else if (rise) begin
            if (nxt_rst) begin
                ir_q <= `TAPP_IR_IDREAD;
            end
            if (cap_ir) begin
                irsh_q <= `TAPP_IR_CAPVAL;
            end else if (sh_ir) begin
                irsh_q <= {tdi_s, irsh_q[3:1]}; // [R2] [R8]
            end
            if (upd_ir) begin
                ir_q <= irsh_q;
            end
            if (cap_dr) begin
                idsh_q <= `TAPP_ID_VALUE;
                cap_q  <= capture_in;
                byp_q  <= 1'b0;
            end else if (sh_dr) begin
                if (sel_id) begin
                    idsh_q <= {tdi_s, idsh_q[IDW-1:1]}; // [R2] [R8]
                end else if (sel_cap) begin
                    cap_q <= {tdi_s, cap_q[IDW-1:1]}; // [R2] [R8]
                end else begin
                    byp_q <= tdi_s; // [R2]
                end
            end
            if (upd_dr && sel_cap) begin
                upd_q <= cap_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Serial output on falling test clock edge
    // ------------------------------------------------------------
    // Output enable follows the shift state at each falling edge
    always @(posedge sys_clk or negedge trst_a_n) begin
        if (!trst_a_n) begin
            tdo_q  <= 1'b0;
            oe_n_q <= 1'b1;
        end else if (fall) begin
            oe_n_q <= ~(sh_ir | sh_dr); // [R4]
            if (sh_ir) begin
                tdo_q <= irsh_q[0]; // [R3]
            end else if (sh_dr) begin
                tdo_q <= sel_id ? idsh_q[0] :
                         (sel_cap ? cap_q[0] : byp_q); // [R3]
            end
        end
    end

    // ------------------------------------------------------------
    // Port outputs
    // ------------------------------------------------------------
    assign tdo_out    = tdo_q;
    assign tdo_oe_n   = oe_n_q;
    assign instr_out  = ir_q;
    assign update_out = upd_q;
endmodule // tapp_top
`default_nettype wire

// ==== tapp_regs.vh ====
`ifndef TAPP_REGS_VH
`define TAPP_REGS_VH
// TAP state codes (one-hot, 16 states)
`define TAPP_ST_RESET    16'h0001
`define TAPP_ST_IDLE     16'h0002
`define TAPP_ST_SEL_DR   16'h0004
`define TAPP_ST_CAP_DR   16'h0008
`define TAPP_ST_SH_DR    16'h0010
`define TAPP_ST_EX1_DR   16'h0020
`define TAPP_ST_PAU_DR   16'h0040
`define TAPP_ST_EX2_DR   16'h0080
`define TAPP_ST_UPD_DR   16'h0100
`define TAPP_ST_SEL_IR   16'h0200
`define TAPP_ST_CAP_IR   16'h0400
`define TAPP_ST_SH_IR    16'h0800
`define TAPP_ST_EX1_IR   16'h1000
`define TAPP_ST_PAU_IR   16'h2000
`define TAPP_ST_EX2_IR   16'h4000
`define TAPP_ST_UPD_IR   16'h8000
// Instruction codes
`define TAPP_IR_WIDTH    4
`define TAPP_IR_IDREAD   4'h2
`define TAPP_IR_BYPASS   4'hf
`define TAPP_IR_CAPTURE  4'h1
// Value loaded into the instruction shift register at capture
`define TAPP_IR_CAPVAL   4'h1
// Identification register capture content (arbitrary value)
`define TAPP_ID_VALUE    32'h0000_0001
`endif

// ==== tapp_sync.v ====
`timescale 1ns/10ps
`default_nettype none
module tapp_sync #(
    parameter W = 4
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] din,
    output wire [W-1:0] dout
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end
    assign dout = sync_q;
endmodule // tapp_sync
`default_nettype wire

// ==== tapp_top_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module tapp_top_properties #(
    parameter IDW = 32
) (
    input wire logic           sys_clk,
    input wire logic           resetn,
    input wire logic           tck,
    input wire logic           tms,
    input wire logic           tdi,
    input wire logic           trst_n,
    input wire logic [IDW-1:0] capture_in,
    input wire logic           tdo_out,
    input wire logic           tdo_oe_n,
    input wire logic [3:0]     instr_out,
    input wire logic [IDW-1:0] update_out
);
    logic       tck_q;
    logic       rise;
    logic [3:0] fall_q;
    logic [3:0] edge_q;
    logic [2:0] ones_q;
    logic       held;
    assign rise = tck && !tck_q;
    assign held = trst_n;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tck_q  <= 1'b0;
            fall_q <= 4'hf;
            edge_q <= 4'hf;
            ones_q <= 3'h0;
        end else begin
            tck_q  <= tck;
            fall_q <= (tck_q && !tck) ? 4'h0 : fall_q + {3'h0, fall_q != 4'hf};
            edge_q <= (tck_q != tck) ? 4'h0 : edge_q + {3'h0, edge_q != 4'hf};
            if (rise) begin
                ones_q <= tms ? ones_q + {2'h0, ones_q != 3'h7} : 3'h0;
            end
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    a_trst_clears: assert property (!trst_n [*2] |->
        instr_out == 4'h2 && update_out == '0) else $error("trst clear");
    a_trst_floats: assert property (!trst_n [*2] |->
        tdo_oe_n && !tdo_out) else $error("trst float");
    a_tdo_on_fall: assert property ($changed(tdo_out) && held
        && $past(held) |-> fall_q <= 4'd7) else $error("tdo timing");
    a_oe_on_fall: assert property ($changed(tdo_oe_n) && held
        && $past(held) |-> fall_q <= 4'd7) else $error("oe timing");
    a_instr_on_edge: assert property ($changed(instr_out) && held
        && $past(held) |-> edge_q <= 4'd7) else $error("instr timing");
    a_update_on_edge: assert property ($changed(update_out) && held
        && $past(held) |-> edge_q <= 4'd7) else $error("update timing");
    a_five_ones: assert property (rise && tms && ones_q == 3'h4 |->
        ##8 instr_out == 4'h2 && tdo_oe_n) else $error("tms reset");
    c_shift: cover property ($fell(tdo_oe_n));
    c_update: cover property ($changed(update_out));
    c_trst: cover property (!trst_n [*2]);
endmodule // tapp_top_properties
bind tapp_top tapp_top_properties #(.IDW(IDW)) i_tapp_top_properties (
    .sys_clk(sys_clk), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .capture_in(capture_in), .tdo_out(tdo_out),
    .tdo_oe_n(tdo_oe_n), .instr_out(instr_out), .update_out(update_out)
);
`default_nettype wire

// ==== tapp_ctl.sv ====
`timescale 1ns/10ps
`default_nettype none
module tapp_ctl (
    input  wire logic sys_clk,
    input  wire logic tdo_out,
    input  wire logic tdo_oe_n,
    output var  logic tck,
    output var  logic tms,
    output var  logic tdi,
    output var  logic trst_n
);
    logic tdo_seen;
    logic oe_seen;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        trst_n = 1'b1;
    end
    // One test clock period of 400 ns, output sampled before next rise
    task automatic step(input logic ms, input logic di);
        tms = ms;
        tdi = di;
        @(negedge sys_clk);
        tck = 1'b1;
        repeat (4) @(negedge sys_clk);
        tck = 1'b0;
        tdi = ~di;
        repeat (3) @(negedge sys_clk);
        tdo_seen = tdo_out;
        oe_seen = tdo_oe_n;
    endtask
    task automatic set_trst(input logic level);
        trst_n = level;
    endtask
endmodule // tapp_ctl
`default_nettype wire

// ==== tapp_top_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "tapp_regs.vh"
module tapp_top_tb_top;
    logic        sys_clk;
    logic        resetn;
    logic        tck, tms, tdi, trst_n, tdo_out, tdo_oe_n;
    logic [3:0]  instr_out;
    logic [31:0] capture_in;
    logic [31:0] update_out;
    logic [31:0] d;
    int          fail_count, samples_checked, cycles;
    tapp_top i_tapp_top (.sys_clk(sys_clk), .resetn(resetn), .tck(tck),
        .tms(tms), .tdi(tdi), .trst_n(trst_n), .capture_in(capture_in),
        .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n), .instr_out(instr_out),
        .update_out(update_out));
    tapp_ctl i_ctl (.sys_clk(sys_clk), .tdo_out(tdo_out),
        .tdo_oe_n(tdo_oe_n), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic shift(input int n, input logic [31:0] din);
        d = '0;
        for (int i = 0; i < n; i++) begin
            check(i_ctl.oe_seen, 1'b0);
            d[i] = i_ctl.tdo_seen;
            i_ctl.step(i == n - 1, din[i]);
        end
        check(i_ctl.oe_seen, 1'b1);
        i_ctl.step(1'b1, 1'b0);
        i_ctl.step(1'b0, 1'b1);
        check(i_ctl.oe_seen, 1'b1);
    endtask
    task automatic ir(input logic [3:0] code);
        i_ctl.step(1'b1, 1'b0);
        i_ctl.step(1'b1, 1'b0);
        i_ctl.step(1'b0, 1'b0);
        i_ctl.step(1'b0, 1'b0);
        shift(4, {28'h0, code});
        check(d, 32'h1);
        check(instr_out, code);
    endtask
    task automatic dr(input int n, input logic [31:0] din);
        i_ctl.step(1'b1, 1'b0);
        i_ctl.step(1'b0, 1'b0);
        i_ctl.step(1'b0, 1'b0);
        shift(n, din);
    endtask
    task automatic test_user_reg();
        ir(4'h1);
        dr(32, 32'h1234_abcd);
        check(d, 32'h96c3_5a0f);
        check(update_out, 32'h1234_abcd);
    endtask
    task automatic test_bypass();
        ir(4'hf);
        dr(4, 32'hb);
        check(d, 32'h6);
        check(update_out, 32'h1234_abcd);
    endtask
    task automatic test_trst_mid_scan();
        i_ctl.step(1'b1, 1'b0);
        i_ctl.step(1'b0, 1'b0);
        i_ctl.step(1'b0, 1'b0);
        i_ctl.set_trst(1'b0);
        repeat (3) @(negedge sys_clk);
        check(instr_out, 4'h2);
        check(update_out, 32'h0);
        check(tdo_oe_n, 1'b1);
        i_ctl.set_trst(1'b1);
        repeat (4) @(negedge sys_clk);
        i_ctl.step(1'b0, 1'b0);
        dr(32, 32'h0);
        check(d, `TAPP_ID_VALUE);
    endtask
    task automatic test_tms_reset();
        ir(4'h1);
        for (int i = 0; i < 5; i++) begin
            i_ctl.step(1'b1, 1'b0);
        end
        i_ctl.step(1'b0, 1'b0);
        check(instr_out, 4'h2);
    endtask
    initial begin
        sys_clk = 1'b1;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            report_and_stop();
        end
    end
    initial begin
        resetn = 1'b0;
        capture_in = 32'h96c3_5a0f;
        repeat (12) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (4) @(negedge sys_clk);
        i_ctl.step(1'b0, 1'b0);
        test_user_reg();
        test_bypass();
        test_trst_mid_scan();
        test_tms_reset();
        report_and_stop();
    end
endmodule // tapp_top_tb_top
`default_nettype wire
